// ===== testbench.sv
// Self-checking bench for the ten-millisecond timer bank.
// Assumes the scan model drives instructions and the bench is the AXI4-Lite master.
`timescale 1ns/100ps
module testbench;
   localparam int T = 10;
   logic sys_clk, reset_n, awvalid, wvalid, bready, arvalid, rready;
   logic [4:0] awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, r;
   logic awready, wready, bvalid, arready, rvalid;
   logic o_exec_done, o_exec_flag, o_error_flag, exec_valid, rti_valid, force_valid, mode_chg;
   logic [15:0] o_exec_pv, sv;
   logic [31:0] pv, st;
   logic [7:0] idx;
   logic b;
   tmh_pkg::tmh_exec_s exec_s;
   tmh_pkg::tmh_rti_s rti_s;
   tmh_pkg::tmh_force_s force_s;
   int fail_count, cmp_count, cyc, seed, start, el;

   tmh_scan_model tmh_scan_model_inst (.i_sys_clk(sys_clk), .o_exec_valid(exec_valid),
      .o_exec(exec_s), .o_rti_valid(rti_valid), .o_rti(rti_s), .o_force_valid(force_valid),
      .o_force(force_s), .o_mode_change(mode_chg));
   tmh_timer #(.TICK_CYCLES(T)) tmh_timer_inst (.i_sys_clk(sys_clk), .i_reset_n(reset_n),
      .i_exec_valid(exec_valid), .i_exec(exec_s), .i_rti_valid(rti_valid), .i_rti(rti_s),
      .i_force_valid(force_valid), .i_force(force_s), .i_mode_change(mode_chg),
      .o_exec_done(o_exec_done), .o_exec_pv(o_exec_pv), .o_exec_flag(o_exec_flag),
      .o_error_flag(o_error_flag), .i_s_awvalid(awvalid), .o_s_awready(awready),
      .i_s_awaddr(awaddr), .i_s_wvalid(wvalid), .o_s_wready(wready), .i_s_wdata(wdata),
      .i_s_wstrb(wstrb), .o_s_bvalid(bvalid), .i_s_bready(bready), .o_s_bresp(bresp),
      .i_s_arvalid(arvalid), .o_s_arready(arready), .i_s_araddr(araddr),
      .o_s_rvalid(rvalid), .i_s_rready(rready), .o_s_rdata(rdata), .o_s_rresp(rresp));

   always #2 sys_clk = ~sys_clk;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic finish_test();
      $display("checks %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : finish_test

   // Hang guard sized well above the full sequence
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 30000) begin
         fail_count++;
         finish_test();
      end
   end

   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask : chk

   function automatic logic bcd_valid(input logic [15:0] v);
      bcd_valid = 1'b1;
      for (int i = 0; i < 4; i++) if (v[4*i +: 4] > 4'h9) bcd_valid = 1'b0;
   endfunction : bcd_valid

   task automatic axi_wr(input logic [4:0] a, input logic [31:0] dw, output logic [1:0] rs);
      @(posedge sys_clk);
      awaddr  <= a;
      wdata   <= dw;
      wstrb   <= 4'hF;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      forever begin
         @(posedge sys_clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            rs = bresp;
            bready <= 1'b0;
            break;
         end
      end
   endtask : axi_wr

   task automatic axi_rd(input logic [4:0] a, output logic [31:0] dr, output logic [1:0] rs);
      @(posedge sys_clk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      forever begin
         @(posedge sys_clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            dr = rdata;
            rs = rresp;
            rready <= 1'b0;
            break;
         end
      end
   endtask : axi_rd

   task automatic sel_rd(input logic [7:0] i, output logic [31:0] p, output logic [31:0] s);
      axi_wr(tmh_pkg::ADDR_SELECT, {24'h0, i}, r);
      axi_rd(tmh_pkg::ADDR_PV, p, r);
      axi_rd(tmh_pkg::ADDR_STATUS, s, r);
   endtask : sel_rd

   // Control bits: input, binary form, interlocked, jumped
   task automatic ex(input logic [7:0] i, input logic [3:0] ctl, input logic [15:0] s);
      tmh_scan_model_inst.exec(i, ctl, s);
      #1;
      chk("exec_done", o_exec_done, 1'b1);
   endtask : ex

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      sys_clk = 0; reset_n = 0; seed = 83687; fail_count = 0; cmp_count = 0; cyc = 0;
      {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, wstrb} = '0;
      repeat (12) @(posedge sys_clk);
      reset_n <= 1'b1;
      sel_rd(8'h05, pv, st);
      chk("pv_reset", pv, 32'h0);
      chk("flag_reset", st[0], 1'b0);
      axi_rd(5'h14, d, r);
      chk("unmapped_rd_resp", r, tmh_pkg::RESP_SLVERR);
      chk("unmapped_rd_data", d, 32'h0);
      axi_wr(5'h18, 32'h1, r);
      chk("unmapped_wr", r, tmh_pkg::RESP_SLVERR);
      for (int n = 0; n < 18; n++) begin
         idx = 8'($random(seed));
         b = 1'($random(seed));
         sv = 16'($random(seed));
         if (n < 2) {b, sv} = n ? {1'b1, 16'hFFFF} : {1'b0, 16'h9999};
         else if (!b) sv = sv & 16'h7777;
         ex(idx, {1'b0, b, 2'b00}, sv);
         chk("load_pv", o_exec_pv, sv);
         chk("load_flag", o_exec_flag, 1'b0);
         chk("load_err", o_error_flag, 1'b0);
         sel_rd(idx, pv, st);
         chk("sel_pv", pv, {16'h0, sv});
      end
      for (int f = 0; f < 2; f++) begin
         sv = f ? 16'h000C : 16'h0012;
         ex(8'h21, {1'b0, f[0], 2'b00}, sv);
         ex(8'h21, {1'b1, f[0], 2'b00}, sv);
         start = cyc;
         chk("start_flag", o_exec_flag, 1'b0);
         while (o_exec_flag !== 1'b1 && cyc - start < 400) begin
            ex(8'h21, {1'b1, f[0], 2'b00}, sv);
            if (f == 0) chk("pv_bcd", bcd_valid(o_exec_pv), 1'b1);
         end
         el = cyc - start;
         chk("not_early", el >= 12 * T, 1'b1);
         chk("late_bound", el <= 13 * T + 4, 1'b1);
         ex(8'h21, {1'b1, f[0], 2'b00}, sv);
         chk("hold_after", {o_exec_flag, o_exec_pv}, {1'b1, 16'h0});
      end
      axi_wr(tmh_pkg::ADDR_SELECT, 32'h21, r);
      axi_wr(tmh_pkg::ADDR_PV, 32'h3, r);
      axi_rd(tmh_pkg::ADDR_STATUS, st, r);
      chk("flag_waits", st[0], 1'b1);
      ex(8'h21, 4'b1100, sv);
      chk("restart_flag", o_exec_flag, 1'b0);
      ex(8'h22, 4'b0000, 16'h0000);
      ex(8'h22, 4'b1000, 16'h0000);
      chk("zero_sv", {o_exec_flag, o_exec_pv}, {1'b1, 16'h0});
      tmh_scan_model_inst.pulse(2'h1, 8'h09, 1'b1, 16'h0);
      sel_rd(8'h09, pv, st);
      chk("force_set", {st[0], pv[15:0]}, {1'b1, 16'h0});
      ex(8'h09, 4'b0001, 16'h0077);
      chk("jumped", {o_exec_flag, o_exec_pv}, {1'b1, 16'h0});
      ex(8'h09, 4'b0000, 16'h00A5);
      chk("bad_bcd", {o_error_flag, o_exec_flag, o_exec_pv}, {2'b11, 16'h0});
      tmh_scan_model_inst.pulse(2'h1, 8'h09, 1'b0, 16'h0042);
      sel_rd(8'h09, pv, st);
      chk("force_reset", {st[0], pv[15:0]}, {1'b0, 16'h0042});
      for (int k = 0; k < 2; k++) begin
         tmh_scan_model_inst.pulse(2'h0, 8'h09, k[0], 16'h0);
         sel_rd(8'h09, pv, st);
         chk("rti_pv", {st[0], pv[15:0]}, {1'b0, k ? 16'hFFFF : 16'h9999});
         ex(8'h09, {1'b1, k[0], 2'b00}, 16'h0300);
         chk("rti_reload", o_exec_pv, 16'h0300);
      end
      ex(8'h09, 4'b1010, 16'h0055);
      chk("interlock", {o_exec_flag, o_exec_pv}, {1'b0, 16'h0055});
      axi_wr(tmh_pkg::ADDR_CTRL, 32'h1, r);
      ex(8'h07, 4'b0000, 16'h1234);
      tmh_scan_model_inst.pulse(2'h2, 8'h00, 1'b0, 16'h0);
      sel_rd(8'h07, pv, st);
      chk("mode_hold", pv, 32'h1234);
      axi_wr(tmh_pkg::ADDR_CTRL, 32'h0, r);
      tmh_scan_model_inst.pulse(2'h2, 8'h00, 1'b0, 16'h0);
      sel_rd(8'h07, pv, st);
      chk("mode_clear", {st[0], pv[15:0]}, {1'b0, 16'h0});
      @(posedge sys_clk);
      reset_n <= 1'b0;
      repeat (12) @(posedge sys_clk);
      reset_n <= 1'b1;
      sel_rd(8'h09, pv, st);
      chk("pv_rereset", {st[0], pv[15:0]}, {1'b0, 16'h0});
      finish_test();
   end
endmodule : testbench

// ===== tmh_pkg.sv
// Package for the ten-millisecond decrementing timer block.
// Assumes a 250 MHz system clock and an AXI4-Lite register port.
package tmh_pkg;

   localparam int          NUM_TIMERS  = 256;
   localparam int          IDX_W       = 8;
   localparam int          PV_W        = 16;
   localparam int          CLK_PER_NS  = 4;
   localparam int          TICK_MS     = 10;
   localparam int          TICK_CYC    = TICK_MS * 1000000 / CLK_PER_NS;
   localparam int          AXI_AW      = 5;

   localparam logic [4:0]  ADDR_CTRL   = 5'h00;
   localparam logic [4:0]  ADDR_SELECT = 5'h04;
   localparam logic [4:0]  ADDR_PV     = 5'h08;
   localparam logic [4:0]  ADDR_STATUS = 5'h0C;
   localparam logic [4:0]  ADDR_TICKS  = 5'h10;

   localparam int          CTRL_HOLD_BIT  = 0;
   localparam int          STAT_DONE_BIT  = 0;
   localparam int          STAT_ERR_BIT   = 1;

   localparam logic [15:0] PV_ZERO     = 16'h0000;
   localparam logic [15:0] PV_ALL_BCD  = 16'h9999;
   localparam logic [15:0] PV_ALL_BIN  = 16'hFFFF;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [7:0]  index;
      logic        timer_input;
      logic        binary;
      logic        interlocked;
      logic        jumped;
      logic [15:0] set_value;
   } tmh_exec_s;

   typedef struct packed {
      logic [7:0]  index;
      logic        force_set;
      logic [15:0] set_value;
   } tmh_force_s;

   typedef struct packed {
      logic [7:0]  index;
      logic        binary;
   } tmh_rti_s;

   function automatic logic bcd_ok(input logic [15:0] v);
      bcd_ok = (v[3:0] < 4'hA) && (v[7:4] < 4'hA) && (v[11:8] < 4'hA) && (v[15:12] < 4'hA);
   endfunction : bcd_ok

   function automatic logic [15:0] bcd2bin(input logic [15:0] v);
      bcd2bin = 16'(v[15:12] * 1000) + 16'(v[11:8] * 100) + 16'(v[7:4] * 10) + 16'(v[3:0]);
   endfunction : bcd2bin

   function automatic logic [15:0] bin2bcd(input logic [15:0] v);
      logic [31:0] s;
      s = {16'h0000, v};
      for (int i = 0; i < 16; i++) begin
         for (int d = 0; d < 4; d++) begin
            if (s[16 + 4 * d +: 4] > 4'h4) begin
               s[16 + 4 * d +: 4] = s[16 + 4 * d +: 4] + 4'h3;
            end
         end
         s = s << 1;
      end
      bin2bcd = s[31:16];
   endfunction : bin2bcd

endpackage : tmh_pkg

// ===== tmh_scan_model.sv
// Scan engine model: issues timer instructions, reset-timer, force and mode pulses.
// Assumes the timer bank takes each request on the edge where its valid is high.
`timescale 1ns/100ps
module tmh_scan_model (
   input  wire logic           i_sys_clk,
   output logic                o_exec_valid,
   output tmh_pkg::tmh_exec_s  o_exec,
   output logic                o_rti_valid,
   output tmh_pkg::tmh_rti_s   o_rti,
   output logic                o_force_valid,
   output tmh_pkg::tmh_force_s o_force,
   output logic                o_mode_change
);
   initial begin
      o_exec_valid  = 1'b0;
      o_exec        = '0;
      o_rti_valid   = 1'b0;
      o_rti         = '0;
      o_force_valid = 1'b0;
      o_force       = '0;
      o_mode_change = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // One instruction per call, so two uses of one index never overlap
   // A scan of two cycles stays far below the four second ceiling
   task automatic exec(input logic [7:0] idx, input logic [3:0] ctl, input logic [15:0] sv);
      @(posedge i_sys_clk);
      o_exec_valid <= 1'b1;
      o_exec       <= {idx, ctl, sv};
      @(posedge i_sys_clk);
      o_exec_valid <= 1'b0;
      // Idle fields flip so a stale value is never mistaken for a request
      o_exec       <= ~{idx, ctl, sv};
   endtask : exec

   // Kind 0 reset-timer, 1 force, 2 mode switch; force before reliance
   task automatic pulse(input logic [1:0] kind, input logic [7:0] idx, input logic b,
                        input logic [15:0] sv);
      @(posedge i_sys_clk);
      o_rti_valid   <= (kind == 2'h0);
      o_rti         <= {idx, b};
      o_force_valid <= (kind == 2'h1);
      o_force       <= {idx, b, sv};
      o_mode_change <= (kind == 2'h2);
      @(posedge i_sys_clk);
      o_rti_valid   <= 1'b0;
      o_rti         <= ~{idx, b};
      o_force_valid <= 1'b0;
      o_force       <= ~{idx, b, sv};
      o_mode_change <= 1'b0;
   endtask : pulse
endmodule : tmh_scan_model

// ===== tmh_timer.sv
// Bank of 256 ten-millisecond decrementing timers evaluated per instruction execution.
// Assumes the scan engine presents one execution per cycle and keeps indices unshared.
`timescale 1ns/100ps

// Functional notes
// - Present value counts down one per 10 ms of elapsed time.
// - Error flag set on bad BCD set value, cleared otherwise.
// - Input low loads set value and keeps completion flag clear.
// - Rising input starts countdown; flag set when value reaches zero.
// - After timeout hold; restart by input cycling or nonzero value write.
// - Preset spans 0 to 99.99 s BCD and 0 to 655.35 s binary.
// - Timeout never early, late by at most one hundredth second.
// - Each valid counting execution (input on, not interlocked or jumped) updates value, then flag equals value is zero.
// - Mode switch clears value and flag unless memory hold is set.
// - Reset-timer loads all nines or all ones, clears flag, reloads later.
// - Interlocked execution reloads set value and clears flag.
// - Jumped execution leaves value and flag unchanged.
// - Forced set gives flag on, value zero; forced reset reloads set value.
// - Timeout sets flag only on execution, so may lag timeout one scan.
module tmh_timer #(
   parameter int TICK_CYCLES = tmh_pkg::TICK_CYC
) (
   input  wire logic                      i_sys_clk,
   input  wire logic                      i_reset_n,
   input  wire logic                      i_exec_valid,
   input  wire tmh_pkg::tmh_exec_s        i_exec,
   input  wire logic                      i_rti_valid,
   input  wire tmh_pkg::tmh_rti_s         i_rti,
   input  wire logic                      i_force_valid,
   input  wire tmh_pkg::tmh_force_s       i_force,
   input  wire logic                      i_mode_change,
   output logic                           o_exec_done,
   output logic [15:0]                    o_exec_pv,
   output logic                           o_exec_flag,
   output logic                           o_error_flag,
   input  wire logic                      i_s_awvalid,
   output logic                           o_s_awready,
   input  wire logic [tmh_pkg::AXI_AW-1:0] i_s_awaddr,
   input  wire logic                      i_s_wvalid,
   output logic                           o_s_wready,
   input  wire logic [31:0]               i_s_wdata,
   input  wire logic [3:0]                i_s_wstrb,
   output logic                           o_s_bvalid,
   input  wire logic                      i_s_bready,
   output logic [1:0]                     o_s_bresp,
   input  wire logic                      i_s_arvalid,
   output logic                           o_s_arready,
   input  wire logic [tmh_pkg::AXI_AW-1:0] i_s_araddr,
   output logic                           o_s_rvalid,
   input  wire logic                      i_s_rready,
   output logic [31:0]                    o_s_rdata,
   output logic [1:0]                     o_s_rresp
);

   localparam int N  = tmh_pkg::NUM_TIMERS;
   localparam int DW = $clog2(TICK_CYCLES);

   logic [15:0]   pv_q    [N];
   logic [15:0]   stamp_q [N];
   logic [N-1:0]  done_q;
   logic [N-1:0]  prev_q;
   logic [N-1:0]  skip_q;
   logic [N-1:0]  reload_q;

   logic [DW-1:0] div_reg;
   logic          tick_reg;
   logic [15:0]   ticks_reg;
   logic          hold_reg;
   logic [7:0]    sel_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Timebase

   // Free-running divider; ticks are only stamped, never pushed into every timer
   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         div_reg  <= '0;
         tick_reg <= 1'b0;
      end else if (div_reg == DW'(TICK_CYCLES - 1)) begin
         div_reg  <= '0;
         tick_reg <= 1'b1;
      end else begin
         div_reg  <= div_reg + 1'b1;
         tick_reg <= 1'b0;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         ticks_reg <= '0;
      end else if (tick_reg) begin
         ticks_reg <= ticks_reg + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Execution evaluation

   logic [15:0] ex_sv;
   logic [15:0] ex_delta;
   logic [15:0] ex_eff;
   logic [15:0] ex_cur;
   logic [15:0] ex_sub;
   logic [15:0] ex_run_pv;
   logic        ex_bad;
   logic        ex_start;
   logic        ex_idle;

   always_comb begin
      ex_sv    = i_exec.set_value;
      ex_bad   = !i_exec.binary && !tmh_pkg::bcd_ok(ex_sv);
      ex_idle  = !i_exec.timer_input || i_exec.interlocked;
      ex_start = i_exec.timer_input && (!prev_q[i_exec.index] || reload_q[i_exec.index]);
      ex_delta = ticks_reg - stamp_q[i_exec.index];
      // The first tick after a start is partial, so it is not counted
      if (skip_q[i_exec.index]) begin
         ex_eff = (ex_delta == 16'h0000) ? 16'h0000 : ex_delta - 16'h0001;
      end else begin
         ex_eff = ex_delta;
      end
      ex_cur = i_exec.binary ? pv_q[i_exec.index] : tmh_pkg::bcd2bin(pv_q[i_exec.index]);
      ex_sub = (ex_cur > ex_eff) ? ex_cur - ex_eff : 16'h0000;
      ex_run_pv = i_exec.binary ? ex_sub : tmh_pkg::bin2bcd(ex_sub);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Timer state: later events in the same cycle override earlier ones on one index

   logic wr_fire;
   logic [4:0]  aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0]  w_strb_reg;
   logic [15:0] sw_pv;

   always_comb begin
      sw_pv = pv_q[sel_reg];
      if (w_strb_reg[0]) sw_pv[7:0] = w_data_reg[7:0];
      if (w_strb_reg[1]) sw_pv[15:8] = w_data_reg[15:8];
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         for (int i = 0; i < N; i++) begin
            pv_q[i]    <= tmh_pkg::PV_ZERO;
            stamp_q[i] <= '0;
         end
         done_q   <= '0;
         prev_q   <= '0;
         skip_q   <= '0;
         reload_q <= '0;
      end else begin
         if (i_mode_change && !hold_reg) begin
            for (int i = 0; i < N; i++) begin
               pv_q[i] <= tmh_pkg::PV_ZERO;
            end
            done_q <= '0;
         end
         // Bad set value leaves the timer untouched; only the error flag reacts
         if (i_exec_valid && !ex_bad && !i_exec.jumped) begin
            reload_q[i_exec.index] <= 1'b0;
            prev_q[i_exec.index]   <= ex_idle ? 1'b0 : 1'b1;
            if (ex_idle) begin
               pv_q[i_exec.index]   <= ex_sv;
               done_q[i_exec.index] <= 1'b0;
            end else if (ex_start) begin
               pv_q[i_exec.index]    <= ex_sv;
               done_q[i_exec.index]  <= (ex_sv == 16'h0000);
               stamp_q[i_exec.index] <= ticks_reg;
               skip_q[i_exec.index]  <= 1'b1;
            end else begin
               pv_q[i_exec.index]    <= ex_run_pv;
               done_q[i_exec.index]  <= (ex_run_pv == 16'h0000);
               stamp_q[i_exec.index] <= ticks_reg;
               skip_q[i_exec.index]  <= skip_q[i_exec.index] && (ex_delta == 16'h0000);
            end
         end
         if (i_rti_valid) begin
            pv_q[i_rti.index]     <= i_rti.binary ? tmh_pkg::PV_ALL_BIN
                                                  : tmh_pkg::PV_ALL_BCD;
            done_q[i_rti.index]   <= 1'b0;
            reload_q[i_rti.index] <= 1'b1;
         end
         if (i_force_valid) begin
            pv_q[i_force.index]   <= i_force.force_set ? tmh_pkg::PV_ZERO
                                                       : i_force.set_value;
            done_q[i_force.index] <= i_force.force_set;
         end
         if (wr_fire && aw_addr_reg == tmh_pkg::ADDR_PV) begin
            pv_q[sel_reg] <= sw_pv;
            // A nonzero write restarts the countdown from this moment
            if (sw_pv != 16'h0000) begin
               stamp_q[sel_reg] <= ticks_reg;
               skip_q[sel_reg]  <= 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Execution result

   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         o_exec_done  <= 1'b0;
         o_exec_pv    <= '0;
         o_exec_flag  <= 1'b0;
         o_error_flag <= 1'b0;
      end else begin
         o_exec_done <= i_exec_valid;
         if (i_exec_valid) begin
            o_error_flag <= ex_bad;
            if (ex_bad || i_exec.jumped) begin
               o_exec_pv   <= pv_q[i_exec.index];
               o_exec_flag <= done_q[i_exec.index];
            end else if (ex_idle) begin
               o_exec_pv   <= ex_sv;
               o_exec_flag <= 1'b0;
            end else if (ex_start) begin
               o_exec_pv   <= ex_sv;
               o_exec_flag <= (ex_sv == 16'h0000);
            end else begin
               o_exec_pv   <= ex_run_pv;
               o_exec_flag <= (ex_run_pv == 16'h0000);
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave

   logic aw_full_reg;
   logic w_full_reg;

   assign wr_fire = aw_full_reg && w_full_reg && !o_s_bvalid;

   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         o_s_awready <= 1'b1;
         o_s_wready  <= 1'b1;
         aw_full_reg <= 1'b0;
         w_full_reg  <= 1'b0;
         aw_addr_reg <= '0;
         w_data_reg  <= '0;
         w_strb_reg  <= '0;
         o_s_bvalid  <= 1'b0;
         o_s_bresp   <= tmh_pkg::RESP_OKAY;
      end else begin
         if (i_s_awvalid && o_s_awready) begin
            o_s_awready <= 1'b0;
            aw_full_reg <= 1'b1;
            aw_addr_reg <= {i_s_awaddr[4:2], 2'h0};
         end
         if (i_s_wvalid && o_s_wready) begin
            o_s_wready <= 1'b0;
            w_full_reg <= 1'b1;
            w_data_reg <= i_s_wdata;
            w_strb_reg <= i_s_wstrb;
         end
         if (wr_fire) begin
            aw_full_reg <= 1'b0;
            w_full_reg  <= 1'b0;
            o_s_bvalid  <= 1'b1;
            o_s_bresp   <= (aw_addr_reg <= tmh_pkg::ADDR_TICKS) ? tmh_pkg::RESP_OKAY
                                                                : tmh_pkg::RESP_SLVERR;
         end
         if (o_s_bvalid && i_s_bready) begin
            o_s_bvalid  <= 1'b0;
            o_s_awready <= 1'b1;
            o_s_wready  <= 1'b1;
         end
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         hold_reg <= 1'b0;
         sel_reg  <= '0;
      end else if (wr_fire) begin
         if (aw_addr_reg == tmh_pkg::ADDR_CTRL && w_strb_reg[0]) begin
            hold_reg <= w_data_reg[tmh_pkg::CTRL_HOLD_BIT];
         end
         if (aw_addr_reg == tmh_pkg::ADDR_SELECT && w_strb_reg[0]) begin
            sel_reg <= w_data_reg[7:0];
         end
      end
   end

   logic [4:0] ra;
   assign ra = {i_s_araddr[4:2], 2'h0};

   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         o_s_arready <= 1'b1;
         o_s_rvalid  <= 1'b0;
         o_s_rdata   <= '0;
         o_s_rresp   <= tmh_pkg::RESP_OKAY;
      end else if (i_s_arvalid && o_s_arready) begin
         o_s_arready <= 1'b0;
         o_s_rvalid  <= 1'b1;
         o_s_rresp   <= tmh_pkg::RESP_OKAY;
         case (ra)
            tmh_pkg::ADDR_CTRL:   o_s_rdata <= {31'h00000000, hold_reg};
            tmh_pkg::ADDR_SELECT: o_s_rdata <= {24'h000000, sel_reg};
            tmh_pkg::ADDR_PV:     o_s_rdata <= {16'h0000, pv_q[sel_reg]};
            tmh_pkg::ADDR_STATUS: o_s_rdata <= {30'h00000000, o_error_flag, done_q[sel_reg]};
            tmh_pkg::ADDR_TICKS:  o_s_rdata <= {16'h0000, ticks_reg};
            default: begin
               o_s_rdata <= '0;
               o_s_rresp <= tmh_pkg::RESP_SLVERR;
            end
         endcase
      end else if (o_s_rvalid && i_s_rready) begin
         o_s_rvalid  <= 1'b0;
         o_s_arready <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_reset_n);

   logic quiet;
   assign quiet = !i_rti_valid && !i_force_valid && !i_mode_change && !wr_fire;

   property p_err_set;
      i_exec_valid && !i_exec.binary && !tmh_pkg::bcd_ok(i_exec.set_value) |=> o_error_flag;
   endproperty
   a_err_set: assert property (p_err_set) else $error("error flag missing");

   property p_err_clr;
      i_exec_valid && (i_exec.binary || tmh_pkg::bcd_ok(i_exec.set_value)) |=> !o_error_flag;
   endproperty
   a_err_clr: assert property (p_err_clr) else $error("error flag stuck");

   property p_idle_load;
      i_exec_valid && !ex_bad && !i_exec.jumped && ex_idle && quiet
      |=> o_exec_done && o_exec_pv == $past(i_exec.set_value) && !o_exec_flag
          && pv_q[$past(i_exec.index)] == $past(i_exec.set_value);
   endproperty
   a_idle_load: assert property (p_idle_load) else $error("idle reload wrong");

   property p_flag_zero;
      o_exec_done && !o_error_flag && !$past(i_exec.jumped) && !$past(ex_idle)
      |-> o_exec_flag == (o_exec_pv == 16'h0000);
   endproperty
   a_flag_zero: assert property (p_flag_zero) else $error("flag disagrees");

   property p_jump_hold;
      i_exec_valid && i_exec.jumped && quiet
      |=> pv_q[$past(i_exec.index)] == $past(pv_q[i_exec.index])
          && done_q[$past(i_exec.index)] == $past(done_q[i_exec.index]);
   endproperty
   a_jump_hold: assert property (p_jump_hold) else $error("jumped timer moved");

   property p_tick;
      div_reg == DW'(TICK_CYCLES - 1) |=> tick_reg ##1 !tick_reg;
   endproperty
   a_tick: assert property (p_tick) else $error("tick missing");

   property p_force;
      i_force_valid && !wr_fire
      |=> done_q[$past(i_force.index)] == $past(i_force.force_set)
          && pv_q[$past(i_force.index)] == ($past(i_force.force_set) ? 16'h0000
                                                                       : $past(i_force.set_value));
   endproperty
   a_force: assert property (p_force) else $error("force result wrong");

   property p_rti;
      i_rti_valid && !i_force_valid && !wr_fire
      |=> !done_q[$past(i_rti.index)] && reload_q[$past(i_rti.index)];
   endproperty
   a_rti: assert property (p_rti) else $error("reset-timer wrong");

   property p_mode;
      i_mode_change && !hold_reg && !i_exec_valid && !i_rti_valid && !i_force_valid
      |=> done_q == '0;
   endproperty
   a_mode: assert property (p_mode) else $error("mode clear missed");

   c_timeout: cover property (o_exec_done && o_exec_flag && !$past(done_q[i_exec.index]));
   c_bad_bcd: cover property (o_error_flag);
   c_force:   cover property (i_force_valid && i_force.force_set);
   c_axi_rd:  cover property (o_s_rvalid && i_s_rready && ra == tmh_pkg::ADDR_PV);

endmodule : tmh_timer
